// >>> shared/rlsh_link_if.sv
// Word-level link between polling master and service-handling slave
`timescale 1ns/1ps
`default_nettype none
interface rlsh_link_if;
	logic reqValid;
	logic reqReady;
	rlsh_pkg::rlsh_service_t reqService;
	logic [7:0] reqNode;
	logic [7:0] reqSet;
	logic [31:0] reqTime;
	logic rspValid;
	rlsh_pkg::rlsh_status_t rspStatus;
	logic [7:0] rspDest;
	logic [7:0] rspSet;
	logic [4:0] rspLen;
	logic rspWordValid;
	logic rspWordReady;
	logic [15:0] rspWord;

	modport master
	(
		output reqValid, reqService, reqNode, reqSet, reqTime, rspWordReady,
		input reqReady, rspValid, rspStatus, rspDest, rspSet, rspLen, rspWordValid, rspWord
	);
	modport slave
	(
		input reqValid, reqService, reqNode, reqSet, reqTime, rspWordReady,
		output reqReady, rspValid, rspStatus, rspDest, rspSet, rspLen, rspWordValid, rspWord
	);
endinterface : rlsh_link_if
`default_nettype wire

// >>> shared/rlsh_pkg.sv
// Shared constants and types of the remote link service handler
package rlsh_pkg;

	// Clock and time base
	localparam int CLK_MHZ = 20;
	localparam int STAMP_UNIT_NS = 100000;
	localparam int TICK_CYCLES = (STAMP_UNIT_NS * CLK_MHZ) / 1000;
	localparam logic [31:0] DAY_TICKS = 32'h337F9800;
	localparam int RSP_TIMEOUT_US = 50;
	localparam int RSP_TIMEOUT_CYCLES = RSP_TIMEOUT_US * CLK_MHZ;

	// Addressing
	localparam logic [7:0] BCAST_NODE = 8'hFF;
	localparam logic [7:0] MASTER_NODE = 8'h00;
	localparam logic [7:0] COLD_SET = 8'h00;
	localparam logic [7:0] ANY_SET = 8'h00;

	// Data set geometry
	localparam int WORD_W = 16;
	localparam logic [3:0] MAX_USER_WORDS = 4'hE;
	localparam logic [4:0] MAX_SET_WORDS = 5'h10;
	localparam logic [4:0] STAMP_WORDS = 5'h02;
	localparam logic [4:0] QUEUE_DEPTH = 5'h14;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] BCAST_REPEATS = 2'h3;

	// Reset values
	localparam logic [31:0] TOD_RESET = 32'h00000000;

	typedef enum logic [2:0]
	{
		SVC_COLD = 3'h0,
		SVC_WARM = 3'h1,
		SVC_NORM = 3'h2,
		SVC_CLOCK = 3'h3,
		SVC_POLL = 3'h4
	} rlsh_service_t;

	typedef enum logic [3:0]
	{
		STS_OK = 4'h0,
		STS_EMPTY = 4'h1,
		STS_EVENT = 4'h2,
		STS_COLD_EVENT = 4'h3,
		STS_NOT_NORM = 4'h4,
		STS_FULL = 4'h5,
		STS_BAD_LEN = 4'h6,
		STS_REFUSED = 4'h7,
		STS_MISMATCH = 4'h8,
		STS_TIMEOUT = 4'h9
	} rlsh_status_t;

endpackage : rlsh_pkg

// >>> src/rlsh_master.sv
// Master end: service sequencing, broadcast repeats, poll collection
`timescale 1ns/1ps
`default_nettype none
module rlsh_master #(parameter logic [31:0] RESYNC_TICKS = rlsh_pkg::DAY_TICKS)
(
	input wire logic clk,
	input wire logic reset,
	rlsh_link_if.master link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire rlsh_pkg::rlsh_service_t cmdService,
	input wire logic [7:0] cmdNode,
	input wire logic [7:0] cmdSet,
	input wire logic [31:0] cmdTime,
	output logic doneValid,
	output rlsh_pkg::rlsh_status_t doneStatus,
	output logic [7:0] doneSet,
	output logic [4:0] doneLen,
	output logic wordValid,
	input wire logic wordReady,
	output logic [15:0] wordData,
	output logic coldIssued,
	output logic clockDue
);
	typedef enum logic [1:0]
	{
		M_IDLE = 2'h0,
		M_REQ = 2'h1,
		M_WAIT = 2'h2,
		M_WORDS = 2'h3
	} rlsh_master_state_t;

	rlsh_master_state_t state_r;
	rlsh_pkg::rlsh_service_t svc_r;
	logic [7:0] node_r, set_r;
	logic [31:0] time_r;
	logic [1:0] repeats_r;
	logic [9:0] timer_r;
	logic [4:0] remain_r;
	logic doneValid_r, coldIssued_r, clockDue_r;
	rlsh_pkg::rlsh_status_t doneStatus_r;
	logic [7:0] doneSet_r;
	logic [4:0] doneLen_r;
	logic [10:0] tickCnt_r;
	logic [31:0] sinceClock_r;
	logic cmdTake, refuse, reqDone, rspHit, badLen, mismatch, wordXfer, timeout;

	assign cmdReady = state_r == M_IDLE;
	assign cmdTake = cmdValid && cmdReady;
	assign refuse = (!coldIssued_r && cmdService != rlsh_pkg::SVC_COLD)
		|| cmdNode == rlsh_pkg::MASTER_NODE
		|| (cmdNode == rlsh_pkg::BCAST_NODE && cmdService == rlsh_pkg::SVC_POLL);
	assign reqDone = state_r == M_REQ && link.reqReady;
	assign rspHit = state_r == M_WAIT && link.rspValid
		&& link.rspDest == rlsh_pkg::MASTER_NODE;
	assign badLen = link.rspLen[0] || link.rspLen < rlsh_pkg::STAMP_WORDS
		|| link.rspLen > rlsh_pkg::MAX_SET_WORDS;
	assign mismatch = link.rspStatus == rlsh_pkg::STS_EVENT && set_r != rlsh_pkg::ANY_SET
		&& link.rspSet != set_r;
	assign timeout = state_r == M_WAIT && timer_r == 10'(rlsh_pkg::RSP_TIMEOUT_CYCLES - 1);
	assign wordXfer = link.rspWordValid && link.rspWordReady;

	assign link.reqValid = state_r == M_REQ;
	assign link.reqService = svc_r;
	assign link.reqNode = node_r;
	assign link.reqSet = set_r;
	assign link.reqTime = time_r;
	assign link.rspWordReady = state_r == M_WORDS && wordReady;
	assign wordValid = state_r == M_WORDS && link.rspWordValid;
	assign wordData = link.rspWord;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= M_IDLE;
			svc_r <= rlsh_pkg::SVC_COLD;
			node_r <= 8'h00;
			set_r <= 8'h00;
			time_r <= 32'h0;
			repeats_r <= 2'h0;
			timer_r <= 10'h000;
			remain_r <= 5'h00;
		end
		else
			unique case (state_r)
				M_IDLE:
					if (cmdTake && !refuse)
					begin
						state_r <= M_REQ;
						svc_r <= cmdService;
						node_r <= cmdNode;
						set_r <= cmdSet;
						time_r <= cmdTime;
						repeats_r <= (cmdNode == rlsh_pkg::BCAST_NODE)
							? rlsh_pkg::BCAST_REPEATS - 2'h1 : 2'h0;
					end
				M_REQ:
					if (reqDone)
					begin
						timer_r <= 10'h000;
						if (node_r != rlsh_pkg::BCAST_NODE)
							state_r <= M_WAIT;
						else if (repeats_r == 2'h0)
							state_r <= M_IDLE;
						else
							repeats_r <= repeats_r - 2'h1;
					end
				M_WAIT:
					if (rspHit)
					begin
						remain_r <= link.rspLen;
						state_r <= (link.rspLen != 5'h00) ? M_WORDS : M_IDLE;
					end
					else if (timeout)
						state_r <= M_IDLE;
					else
						timer_r <= timer_r + 10'h001;
				M_WORDS:
					if (wordXfer)
					begin
						remain_r <= remain_r - 5'h01;
						if (remain_r == 5'h01)
							state_r <= M_IDLE;
					end
			endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Completion report to the user
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			doneValid_r <= 1'b0;
			doneStatus_r <= rlsh_pkg::STS_OK;
			doneSet_r <= 8'h00;
			doneLen_r <= 5'h00;
		end
		else
		begin
			doneValid_r <= (cmdTake && refuse) || (reqDone && node_r == rlsh_pkg::BCAST_NODE
				&& repeats_r == 2'h0) || (rspHit && link.rspLen == 5'h00) || timeout
				|| (state_r == M_WORDS && wordXfer && remain_r == 5'h01);
			if (cmdTake && refuse)
			begin
				doneStatus_r <= rlsh_pkg::STS_REFUSED;
				doneSet_r <= cmdSet;
				doneLen_r <= 5'h00;
			end
			else if (reqDone)
			begin
				doneStatus_r <= rlsh_pkg::STS_OK;
				doneSet_r <= set_r;
				doneLen_r <= 5'h00;
			end
			else if (timeout)
				doneStatus_r <= rlsh_pkg::STS_TIMEOUT;
			else if (rspHit)
			begin
				doneSet_r <= link.rspSet;
				doneLen_r <= link.rspLen;
				if (link.rspLen != 5'h00 && badLen)
					doneStatus_r <= rlsh_pkg::STS_BAD_LEN;
				else if (mismatch)
					doneStatus_r <= rlsh_pkg::STS_MISMATCH;
				else
					doneStatus_r <= link.rspStatus;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Cold start bookkeeping and clock resync reminder
	always_ff @(posedge clk)
	begin
		if (reset)
			coldIssued_r <= 1'b0;
		else if (reqDone && svc_r == rlsh_pkg::SVC_COLD)
			coldIssued_r <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset || (reqDone && svc_r == rlsh_pkg::SVC_CLOCK))
		begin
			tickCnt_r <= 11'h000;
			sinceClock_r <= 32'h0;
		end
		else if (tickCnt_r == 11'(rlsh_pkg::TICK_CYCLES - 1))
		begin
			tickCnt_r <= 11'h000;
			if (sinceClock_r != RESYNC_TICKS)
				sinceClock_r <= sinceClock_r + 32'h1;
		end
		else
			tickCnt_r <= tickCnt_r + 11'h001;
	end

	// Reminder set wins over its clear
	always_ff @(posedge clk)
	begin
		if (reset)
			clockDue_r <= 1'b0;
		else if ((reqDone && svc_r == rlsh_pkg::SVC_COLD) || sinceClock_r == RESYNC_TICKS - 32'h1)
			clockDue_r <= 1'b1;
		else if (reqDone && svc_r == rlsh_pkg::SVC_CLOCK)
			clockDue_r <= 1'b0;
	end

	assign doneValid = doneValid_r;
	assign doneStatus = doneStatus_r;
	assign doneSet = doneSet_r;
	assign doneLen = doneLen_r;
	assign coldIssued = coldIssued_r;
	assign clockDue = clockDue_r;
endmodule : rlsh_master
`default_nettype wire

// >>> src/rlsh_slave.sv
// Slave end: system services, event queue, time stamps, response FIFO
// Behaviour
// - Master sends cold start before anything else
// - Cold start, normalize may use broadcast 255
// - Cold start resets protocol state, empties queue
// - Cold start enqueues one cold-start event
// - Warm start empties the event queue
// - Data sets blocked until normalization after start
// - Unnormalized slave rejects local events with error
// - Poll of unnormalized slave returns error
// - Event: up to 14 words plus stamp
// - Stamp counts 0.1 ms since midnight
// - Stamp high half then low half after data
// - Double words even offset, high word first
// - Slave endpoints address node zero
// - Endpoints paired by identical set number
// - Time of day starts at midnight
// - Master sets time after cold start, daily
// - Slave runs services without local action
// - Events leave only when master polls
// - Queue holds 20; overflow rejected with error
// - Sets carry even word count, at least two
// - No response to broadcast; master repeats it
`timescale 1ns/1ps
`default_nettype none

module rlsh_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 8)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : nextPtr

	assign inReady = count_r != (AW + 1)'(DEPTH);
	assign outValid = count_r != '0;
	assign outData = mem[rdPtr_r];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr_r] <= inData;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wrPtr_r <= nextPtr(wrPtr_r);
			if (pop)
				rdPtr_r <= nextPtr(rdPtr_r);
			count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : rlsh_fifo

////////////////////////////////////////////////////////////////////////////////

module rlsh_slave
(
	input wire logic clk,
	input wire logic reset,
	rlsh_link_if.slave link,
	input wire logic [7:0] myNode,
	input wire logic evValid,
	output logic evReady,
	input wire logic [7:0] evSet,
	input wire logic [3:0] evLen,
	input wire logic evWordValid,
	output logic evWordReady,
	input wire logic [15:0] evWord,
	output logic evDone,
	output rlsh_pkg::rlsh_status_t evStatus,
	output logic normalized,
	output logic [4:0] queueCount,
	output logic [31:0] timeOfDay
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_COLLECT = 2'h1,
		ST_SEND = 2'h2
	} rlsh_slave_state_t;

	localparam int SLOT_WORDS = 20 * 14;

	rlsh_slave_state_t state_r;
	logic norm_r;
	logic [31:0] tod_r;
	logic [10:0] tickCnt_r;
	logic [4:0] wrSlot_r;
	logic [4:0] rdSlot_r;
	logic [4:0] qCount_r;
	logic [3:0] colLen_r;
	logic [3:0] colIdx_r;
	logic [3:0] sendLen_r;
	logic [4:0] sendIdx_r;
	logic rspValid_r;
	rlsh_pkg::rlsh_status_t rspStatus_r;
	logic [7:0] rspSet_r;
	logic [4:0] rspLen_r;
	logic evDone_r;
	rlsh_pkg::rlsh_status_t evStatus_r;
	logic [15:0] wordMem [SLOT_WORDS];
	logic [7:0] setMem [20];
	logic [3:0] lenMem [20];
	logic [31:0] stampMem [20];
	logic single, bcast, take, coldNow, warmNow, normNow, clockNow, pollNow;
	logic evTake, evOk, colWord, colLast, commit, sendPush, sendLast, tick;
	logic queueFull, queueEmpty, fifoInReady;
	logic [15:0] fifoInData;

	function automatic logic [8:0] slotWord(input logic [4:0] slot, input logic [3:0] idx);
		return 9'(slot) * 9'(rlsh_pkg::MAX_USER_WORDS) + 9'(idx);
	endfunction : slotWord

	function automatic logic [4:0] nextSlot(input logic [4:0] s);
		return (s == rlsh_pkg::QUEUE_DEPTH - 5'h01) ? 5'h00 : s + 5'h01;
	endfunction : nextSlot

	////////////////////////////////////////////////////////////////////////////
	// Service decode; link requests win over local events
	assign single = link.reqNode == myNode;
	assign bcast = link.reqNode == rlsh_pkg::BCAST_NODE;
	assign link.reqReady = state_r == ST_IDLE;
	assign take = link.reqValid && link.reqReady
		&& (single || (bcast && link.reqService != rlsh_pkg::SVC_POLL));
	assign coldNow = take && link.reqService == rlsh_pkg::SVC_COLD;
	assign warmNow = take && link.reqService == rlsh_pkg::SVC_WARM;
	assign normNow = take && link.reqService == rlsh_pkg::SVC_NORM;
	assign clockNow = take && link.reqService == rlsh_pkg::SVC_CLOCK;
	assign pollNow = take && link.reqService == rlsh_pkg::SVC_POLL;
	assign queueFull = qCount_r == rlsh_pkg::QUEUE_DEPTH;
	assign queueEmpty = qCount_r == 5'h00;

	assign evReady = state_r == ST_IDLE && !link.reqValid;
	assign evTake = evValid && evReady;
	// Odd user length would put the stamp at an odd offset
	assign evOk = evTake && norm_r && !queueFull && !evLen[0]
		&& evLen <= rlsh_pkg::MAX_USER_WORDS;
	assign evWordReady = state_r == ST_COLLECT;
	assign colWord = evWordReady && evWordValid;
	assign colLast = colWord && colIdx_r == colLen_r - 4'h1;
	assign commit = colLast || (evOk && evLen == 4'h0);
	assign sendPush = state_r == ST_SEND && fifoInReady;
	assign sendLast = sendPush && sendIdx_r == {1'b0, sendLen_r} + 5'h01;
	assign tick = tickCnt_r == 11'(rlsh_pkg::TICK_CYCLES - 1);

	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= ST_IDLE;
		else
			unique case (state_r)
				ST_IDLE:
					if (pollNow && norm_r && !queueEmpty)
						state_r <= ST_SEND;
					else if (evOk && evLen != 4'h0)
						state_r <= ST_COLLECT;
				ST_COLLECT:
					if (colLast)
						state_r <= ST_IDLE;
				ST_SEND:
					if (sendLast)
						state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset || coldNow || warmNow)
			norm_r <= 1'b0;
		else if (normNow)
			norm_r <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Time of day in 0.1 ms units, wraps at midnight
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tickCnt_r <= 11'h000;
			tod_r <= rlsh_pkg::TOD_RESET;
		end
		else if (clockNow)
		begin
			tickCnt_r <= 11'h000;
			tod_r <= (link.reqTime < rlsh_pkg::DAY_TICKS) ? link.reqTime : rlsh_pkg::TOD_RESET;
		end
		else if (tick)
		begin
			tickCnt_r <= 11'h000;
			tod_r <= (tod_r == rlsh_pkg::DAY_TICKS - 32'h1) ? 32'h0 : tod_r + 32'h1;
		end
		else
			tickCnt_r <= tickCnt_r + 11'h001;
	end

	////////////////////////////////////////////////////////////////////////////
	// Event queue: local header written at acceptance, counted at commit; cold event written and counted at once
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wrSlot_r <= 5'h00;
			rdSlot_r <= 5'h00;
			qCount_r <= 5'h00;
		end
		else if (coldNow)
		begin
			wrSlot_r <= 5'h01;
			rdSlot_r <= 5'h00;
			qCount_r <= 5'h01;
		end
		else if (warmNow)
		begin
			wrSlot_r <= 5'h00;
			rdSlot_r <= 5'h00;
			qCount_r <= 5'h00;
		end
		else
		begin
			if (commit)
				wrSlot_r <= nextSlot(wrSlot_r);
			if (sendLast)
				rdSlot_r <= nextSlot(rdSlot_r);
			qCount_r <= qCount_r + 5'(commit) - 5'(sendLast);
		end
	end

	always_ff @(posedge clk)
	begin
		if (coldNow)
		begin
			setMem[0] <= rlsh_pkg::COLD_SET;
			lenMem[0] <= 4'h0;
			stampMem[0] <= tod_r;
		end
		else if (evOk)
		begin
			setMem[wrSlot_r] <= evSet;
			lenMem[wrSlot_r] <= evLen;
			stampMem[wrSlot_r] <= tod_r;
		end
		if (colWord)
			wordMem[slotWord(wrSlot_r, colIdx_r)] <= evWord;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			colLen_r <= 4'h0;
			colIdx_r <= 4'h0;
		end
		else if (evOk)
		begin
			colLen_r <= evLen;
			colIdx_r <= 4'h0;
		end
		else if (colWord)
			colIdx_r <= colIdx_r + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			evDone_r <= 1'b0;
			evStatus_r <= rlsh_pkg::STS_OK;
		end
		else
		begin
			evDone_r <= commit || (evTake && !evOk);
			if (commit)
				evStatus_r <= rlsh_pkg::STS_OK;
			else if (evTake && !norm_r)
				evStatus_r <= rlsh_pkg::STS_NOT_NORM;
			else if (evTake && queueFull)
				evStatus_r <= rlsh_pkg::STS_FULL;
			else if (evTake && !evOk)
				evStatus_r <= rlsh_pkg::STS_BAD_LEN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Poll readout: user words, then stamp high, then stamp low
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sendLen_r <= 4'h0;
			sendIdx_r <= 5'h00;
		end
		else if (pollNow)
		begin
			sendLen_r <= lenMem[rdSlot_r];
			sendIdx_r <= 5'h00;
		end
		else if (sendPush)
			sendIdx_r <= sendIdx_r + 5'h01;
	end

	always_comb
	begin
		if (sendIdx_r < {1'b0, sendLen_r})
			fifoInData = wordMem[slotWord(rdSlot_r, sendIdx_r[3:0])];
		else if (sendIdx_r == {1'b0, sendLen_r})
			fifoInData = stampMem[rdSlot_r][31:16];
		else
			fifoInData = stampMem[rdSlot_r][15:0];
	end

	rlsh_fifo #(.WIDTH(rlsh_pkg::WORD_W), .DEPTH(rlsh_pkg::FIFO_DEPTH)) respFifo
	(
		.clk(clk),
		.reset(reset || coldNow || warmNow),
		.inValid(state_r == ST_SEND),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(link.rspWordValid),
		.outReady(link.rspWordReady),
		.outData(link.rspWord)
	);

	// Broadcasts are taken silently
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rspValid_r <= 1'b0;
			rspStatus_r <= rlsh_pkg::STS_OK;
			rspSet_r <= 8'h00;
			rspLen_r <= 5'h00;
		end
		else
		begin
			rspValid_r <= take && single;
			if (take && single)
			begin
				rspSet_r <= link.reqSet;
				rspLen_r <= 5'h00;
				if (!pollNow)
					rspStatus_r <= rlsh_pkg::STS_OK;
				else if (!norm_r)
					rspStatus_r <= rlsh_pkg::STS_NOT_NORM;
				else if (queueEmpty)
					rspStatus_r <= rlsh_pkg::STS_EMPTY;
				else
				begin
					rspSet_r <= setMem[rdSlot_r];
					rspLen_r <= 5'(lenMem[rdSlot_r]) + rlsh_pkg::STAMP_WORDS;
					rspStatus_r <= (setMem[rdSlot_r] == rlsh_pkg::COLD_SET)
						? rlsh_pkg::STS_COLD_EVENT : rlsh_pkg::STS_EVENT;
				end
			end
		end
	end

	assign link.rspValid = rspValid_r;
	assign link.rspStatus = rspStatus_r;
	assign link.rspDest = rlsh_pkg::MASTER_NODE;
	assign link.rspSet = rspSet_r;
	assign link.rspLen = rspLen_r;
	assign evDone = evDone_r;
	assign evStatus = evStatus_r;
	assign normalized = norm_r;
	assign queueCount = qCount_r;
	assign timeOfDay = tod_r;
endmodule : rlsh_slave
`default_nettype wire

// >>> testbench/remote_link_slave_service_handler_tb_top.sv
// Bench: master and slave ends joined by the link, driven from both user sides
`timescale 1ns/1ps
`default_nettype none
module remote_link_slave_service_handler_tb_top;
	logic clk, reset, cmdValid, cmdReady, doneValid, wordValid, wordReady, evValid, evReady;
	logic evWordValid, evWordReady, evDone, normalized, coldIssued, clockDue;
	rlsh_pkg::rlsh_service_t cmdService;
	rlsh_pkg::rlsh_status_t doneStatus, evStatus;
	logic [7:0] cmdNode, cmdSet, doneSet, evSet, myNode;
	logic [31:0] cmdTime, timeOfDay;
	logic [4:0] doneLen, queueCount;
	logic [3:0] evLen;
	logic [15:0] wordData, evWord;
	logic [15:0] got[$];
	int errors, checked, cycles;
	rlsh_link_if rlsh_link_if_inst ();
	rlsh_master #(.RESYNC_TICKS(32'h10)) rlsh_master_inst (.clk(clk), .reset(reset),
		.link(rlsh_link_if_inst.master), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdService(cmdService), .cmdNode(cmdNode), .cmdSet(cmdSet), .cmdTime(cmdTime),
		.doneValid(doneValid), .doneStatus(doneStatus), .doneSet(doneSet), .doneLen(doneLen),
		.wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
		.coldIssued(coldIssued), .clockDue(clockDue));
	rlsh_slave rlsh_slave_inst (.clk(clk), .reset(reset), .link(rlsh_link_if_inst.slave),
		.myNode(myNode), .evValid(evValid), .evReady(evReady), .evSet(evSet), .evLen(evLen),
		.evWordValid(evWordValid), .evWordReady(evWordReady), .evWord(evWord), .evDone(evDone),
		.evStatus(evStatus), .normalized(normalized), .queueCount(queueCount),
		.timeOfDay(timeOfDay));
	rlsh_link_chk rlsh_link_chk_inst (.clk(clk), .reset(reset),
		.reqValid(rlsh_link_if_inst.reqValid), .reqReady(rlsh_link_if_inst.reqReady),
		.reqService(rlsh_link_if_inst.reqService), .reqNode(rlsh_link_if_inst.reqNode),
		.rspValid(rlsh_link_if_inst.rspValid), .rspStatus(rlsh_link_if_inst.rspStatus),
		.rspDest(rlsh_link_if_inst.rspDest), .rspSet(rlsh_link_if_inst.rspSet),
		.rspLen(rlsh_link_if_inst.rspLen));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	// Master command; words pulled on the way are kept in got
	task automatic cmd(input rlsh_pkg::rlsh_service_t svc, input logic [7:0] node,
		input logic [7:0] set, input logic [31:0] tm, input rlsh_pkg::rlsh_status_t exp);
		int n;
		n = 0;
		got = {};
		cmdValid <= 1'b1;
		cmdService <= svc;
		cmdNode <= node;
		cmdSet <= set;
		cmdTime <= tm;
		do @(posedge clk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		do
		begin
			@(posedge clk);
			n++;
			if (wordValid === 1'b1 && wordReady === 1'b1)
				got.push_back(wordData);
		end
		while (doneValid !== 1'b1 && n < 3000);
		chk("doneStatus", exp, doneStatus);
	endtask : cmd
	// Local event; user word k carries A000 plus k
	task automatic ev(input logic [7:0] set, input logic [3:0] len,
		input rlsh_pkg::rlsh_status_t exp);
		int i;
		int n;
		i = 0;
		n = 0;
		evValid <= 1'b1;
		evSet <= set;
		evLen <= len;
		evWord <= 16'hA000;
		do @(posedge clk); while (evReady !== 1'b1);
		evValid <= 1'b0;
		evWordValid <= (len != 4'h0);
		while (evDone !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
			if (evWordValid === 1'b1 && evWordReady === 1'b1)
			begin
				i++;
				evWord <= 16'hA000 + 16'(i);
				evWordValid <= (i < len);
			end
		end
		evWordValid <= 1'b0;
		chk("evStatus", exp, evStatus);
	endtask : ev
	task automatic words(input int n, input logic [31:0] stamp);
		chk("wordCount", 32'(n + 2), 32'(got.size()));
		for (int k = 0; k < n; k++)
			chk("userWord", 32'(16'hA000 + 16'(k)), got[k]);
		chk("stampHigh", stamp[31:16], got[n]);
		chk("stampLow", stamp[15:0], got[n + 1]);
	endtask : words
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Whole run is a few thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			end_sim();
		end
	end
	initial
	begin
		reset <= 1'b1;
		cmdValid <= 1'b0;
		cmdService <= rlsh_pkg::SVC_COLD;
		cmdNode <= 8'h00;
		cmdSet <= 8'h00;
		cmdTime <= 32'h0;
		wordReady <= 1'b1;
		evValid <= 1'b0;
		evSet <= 8'h00;
		evLen <= 4'h0;
		evWordValid <= 1'b0;
		evWord <= 16'h0000;
		myNode <= 8'h05;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("timeOfDay", 32'h0, timeOfDay);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_REFUSED);
		cmd(rlsh_pkg::SVC_COLD, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_OK);
		chk("queueCount", 32'h1, queueCount);
		chk("coldIssued", 32'h1, coldIssued);
		chk("clockDue", 32'h1, clockDue);
		ev(8'h11, 4'h2, rlsh_pkg::STS_NOT_NORM);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_NOT_NORM);
		cmd(rlsh_pkg::SVC_NORM, 8'hFF, 8'h00, 32'h0, rlsh_pkg::STS_OK);
		chk("normalized", 32'h1, normalized);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_COLD_EVENT);
		words(0, 32'h0);
		cmd(rlsh_pkg::SVC_CLOCK, 8'hFF, 8'h00, 32'h1FAAFEA0, rlsh_pkg::STS_OK);
		chk("timeOfDay", 32'h1FAAFEA0, timeOfDay);
		chk("clockDue", 32'h0, clockDue);
		repeat (2000) @(posedge clk);
		chk("timeOfDay", 32'h1FAAFEA1, timeOfDay);
		ev(8'h13, 4'h4, rlsh_pkg::STS_OK);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h13, 32'h0, rlsh_pkg::STS_EVENT);
		chk("doneSet", 32'h13, doneSet);
		words(4, 32'h1FAAFEA1);
		ev(8'h15, 4'h3, rlsh_pkg::STS_BAD_LEN);
		ev(8'h16, 4'hE, rlsh_pkg::STS_OK);
		// Stalled reader makes the reply buffer fill and hold the readout
		wordReady <= 1'b0;
		fork
			cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h16, 32'h0, rlsh_pkg::STS_EVENT);
			begin
				repeat (60) @(posedge clk);
				wordReady <= 1'b1;
			end
		join
		chk("doneLen", 32'h10, doneLen);
		words(14, 32'h1FAAFEA1);
		ev(8'h22, 4'h2, rlsh_pkg::STS_OK);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h23, 32'h0, rlsh_pkg::STS_MISMATCH);
		cmd(rlsh_pkg::SVC_POLL, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_EMPTY);
		repeat (20) ev(8'h30, 4'h0, rlsh_pkg::STS_OK);
		ev(8'h31, 4'h0, rlsh_pkg::STS_FULL);
		chk("queueCount", 32'h14, queueCount);
		cmd(rlsh_pkg::SVC_WARM, 8'h05, 8'h00, 32'h0, rlsh_pkg::STS_OK);
		chk("queueCount", 32'h0, queueCount);
		chk("normalized", 32'h0, normalized);
		cmd(rlsh_pkg::SVC_COLD, 8'hFF, 8'h00, 32'h0, rlsh_pkg::STS_OK);
		chk("queueCount", 32'h1, queueCount);
		end_sim();
	end
endmodule : remote_link_slave_service_handler_tb_top
`default_nettype wire

// >>> testbench/rlsh_link_chk.sv
// Checker of the link between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module rlsh_link_chk
(
	input wire logic clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire rlsh_pkg::rlsh_service_t reqService,
	input wire logic [7:0] reqNode,
	input wire logic rspValid,
	input wire rlsh_pkg::rlsh_status_t rspStatus,
	input wire logic [7:0] rspDest,
	input wire logic [7:0] rspSet,
	input wire logic [4:0] rspLen
);
	logic take;
	logic unNorm_r;
	logic coldSeen_r;
	assign take = reqValid && reqReady;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// Bench only ever addresses its own slave or all slaves
	always_ff @(posedge clk)
	begin
		if (reset)
			unNorm_r <= 1'b1;
		else if (take && reqService == rlsh_pkg::SVC_NORM)
			unNorm_r <= 1'b0;
		else if (take && (reqService == rlsh_pkg::SVC_COLD || reqService == rlsh_pkg::SVC_WARM))
			unNorm_r <= 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			coldSeen_r <= 1'b0;
		else if (take && reqService == rlsh_pkg::SVC_COLD)
			coldSeen_r <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_coldFirst;
		reqValid && !coldSeen_r |-> reqService == rlsh_pkg::SVC_COLD;
	endproperty
	a_coldFirst: assert property (p_coldFirst)
		else $error("request before any cold start");
	property p_destZero;
		rspValid |-> rspDest == rlsh_pkg::MASTER_NODE;
	endproperty
	a_destZero: assert property (p_destZero)
		else $error("reply not sent to node zero");
	property p_noBcastRsp;
		take && reqNode == rlsh_pkg::BCAST_NODE |=> !rspValid;
	endproperty
	a_noBcastRsp: assert property (p_noBcastRsp)
		else $error("reply to broadcast");
	property p_pollAnswer;
		take && reqService == rlsh_pkg::SVC_POLL |=> rspValid ##1 !rspValid;
	endproperty
	a_pollAnswer: assert property (p_pollAnswer)
		else $error("poll reply missing or not a pulse");
	property p_notNorm;
		take && reqService == rlsh_pkg::SVC_POLL && unNorm_r |=> rspStatus == rlsh_pkg::STS_NOT_NORM;
	endproperty
	a_notNorm: assert property (p_notNorm)
		else $error("poll of idle slave gave data");
	property p_coldRsp;
		take && reqService == rlsh_pkg::SVC_COLD && reqNode != rlsh_pkg::BCAST_NODE
			|=> rspValid && rspStatus == rlsh_pkg::STS_OK;
	endproperty
	a_coldRsp: assert property (p_coldRsp)
		else $error("cold start not answered");
	property p_evenLen;
		rspValid && rspStatus == rlsh_pkg::STS_EVENT |-> !rspLen[0] && rspLen >= 5'h02 && rspLen <= 5'h10;
	endproperty
	a_evenLen: assert property (p_evenLen)
		else $error("event length out of range");
	property p_coldEvent;
		rspValid && rspStatus == rlsh_pkg::STS_COLD_EVENT |-> rspLen == 5'h02 && rspSet == 8'h00;
	endproperty
	a_coldEvent: assert property (p_coldEvent)
		else $error("cold event shape wrong");
endmodule : rlsh_link_chk
`default_nettype wire
